//--- core/spi_slave_framing.sv
// Serial slave port framing with word exchange and read response
`timescale 1ns/10ps
`default_nettype none
module spi_slave_framing
    import spi_por_pkg::*;
#(
    parameter int unsigned RELEASE_CYCLES = POR_CYCLES
) (
    input wire logic clock,            // System clock, 100 MHz
    input wire logic supply_ok,        // Supply above threshold, asynchronous
    input wire logic rst_n,            // External reset, active low
    input wire logic sclk,             // Serial clock from master
    input wire logic cs_n,             // Chip select, active low
    input wire logic sdi,              // Serial data in
    output logic sdo,                  // Serial data out
    output logic sdo_oe,               // Serial data out enable
    output logic cmd_valid,            // Command word received, pulse (clock)
    output cmd_word_t cmd_word,        // Received command word
    input wire logic [WORD_BITS-1:0] rd_data, // Read data for cmd_word.addr
    output logic dev_rst_n             // Device reset released, level
);
    logic por_rst_n;
    logic link_rst_n;
    logic [CNT_W-1:0] bit_cnt_ff;
    logic [WORD_BITS-1:0] rx_sh_ff;
    logic [WORD_BITS-1:0] tx_sh_ff;
    logic [WORD_BITS-1:0] rd_hold_ff;
    logic [WORD_BITS-1:0] nxt_rx;
    logic word_tgl_ff;
    logic [WORD_BITS-1:0] word_ff;
    logic tgl_meta_ff;
    logic tgl_sync_ff;
    logic tgl_seen_ff;
    logic rst_meta_ff;
    logic rst_sync_ff;

    por_timer #(
        .RELEASE_CYCLES(RELEASE_CYCLES)
    ) u_por (
        .clock(clock),
        .supply_ok(supply_ok),
        .sys_rst_n(por_rst_n)
    );

    assign dev_rst_n = por_rst_n & rst_n;
    // Chip select high also resets the link side, so each frame starts clean
    assign link_rst_n = dev_rst_n & ~cs_n;

    // Reset release brought onto the system clock before pulses are let out
    always_ff @(posedge clock or negedge dev_rst_n) begin
        if (!dev_rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    assign nxt_rx = {rx_sh_ff[WORD_BITS-2:0], sdi};

    always_ff @(posedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_cnt_ff <= '0;
        end else begin
            bit_cnt_ff <= bit_cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            rx_sh_ff <= '0;
        end else begin
            rx_sh_ff <= nxt_rx;
        end
    end

    // Word handed across as a held register plus a toggle event
    always_ff @(posedge sclk or negedge dev_rst_n) begin
        if (!dev_rst_n) begin
            word_ff <= '0;
            word_tgl_ff <= 1'b0;
        end else if (!cs_n && bit_cnt_ff == LAST_BIT) begin
            word_ff <= nxt_rx;
            word_tgl_ff <= ~word_tgl_ff;
        end
    end

    // Answer taken at the first rise of the word, not at the end of the command:
    // at that end the command has not yet crossed, so the reply would slip a word
    always_ff @(posedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            tx_sh_ff <= '0;
        end else if (bit_cnt_ff == '0) begin
            tx_sh_ff <= {rd_hold_ff[WORD_BITS-2:0], 1'b0};
        end else begin
            tx_sh_ff <= {tx_sh_ff[WORD_BITS-2:0], 1'b0};
        end
    end

    // First bit comes from the staged answer, settled during the gap between words
    assign sdo = (bit_cnt_ff == '0) ? rd_hold_ff[WORD_BITS-1] : tx_sh_ff[WORD_BITS-1];
    assign sdo_oe = ~cs_n;

    always_ff @(posedge clock or negedge dev_rst_n) begin
        if (!dev_rst_n) begin
            tgl_meta_ff <= 1'b0;
            tgl_sync_ff <= 1'b0;
            tgl_seen_ff <= 1'b0;
        end else begin
            tgl_meta_ff <= word_tgl_ff;
            tgl_sync_ff <= tgl_meta_ff;
            tgl_seen_ff <= tgl_sync_ff;
        end
    end

    always_ff @(posedge clock or negedge dev_rst_n) begin
        if (!dev_rst_n) begin
            cmd_valid <= 1'b0;
            cmd_word <= '0;
        end else begin
            cmd_valid <= rst_sync_ff && (tgl_sync_ff != tgl_seen_ff);
            if (tgl_sync_ff != tgl_seen_ff) begin
                cmd_word <= cmd_word_t'(word_ff);
            end
        end
    end

    // Read answer staged for the following word; writes answer zero
    always_ff @(posedge clock or negedge dev_rst_n) begin
        if (!dev_rst_n) begin
            rd_hold_ff <= '0;
        end else if (cmd_valid) begin
            rd_hold_ff <= cmd_word.wnr ? '0 : rd_data;
        end
    end

    a_bit_count: assert property (@(posedge sclk) disable iff (!link_rst_n)
        bit_cnt_ff == LAST_BIT |=> bit_cnt_ff == '0)
        else $error("bit counter did not wrap at word end");
    a_shift_in: assert property (@(posedge sclk) disable iff (!link_rst_n)
        1'b1 |=> rx_sh_ff[0] == $past(sdi))
        else $error("input bit not captured");
    a_shift_out: assert property (@(posedge sclk) disable iff (!link_rst_n)
        bit_cnt_ff != '0 |=> tx_sh_ff[WORD_BITS-1] == $past(tx_sh_ff[WORD_BITS-2]))
        else $error("output not shifted MSB first");
    a_resp_load: assert property (@(posedge sclk) disable iff (!link_rst_n)
        bit_cnt_ff == '0 |=> tx_sh_ff[WORD_BITS-1:1] == $past(rd_hold_ff[WORD_BITS-2:0]))
        else $error("response not loaded at word boundary");
    a_word_capture: assert property (@(posedge sclk) disable iff (!link_rst_n)
        bit_cnt_ff == LAST_BIT |=> word_ff == $past(nxt_rx))
        else $error("word not captured");
    a_idle_count: assert property (@(posedge clock) disable iff (!dev_rst_n)
        cs_n |-> bit_cnt_ff == '0)
        else $error("bit counter active while deselected");
    a_oe_frame: assert property (@(posedge clock) disable iff (!dev_rst_n)
        sdo_oe == !cs_n)
        else $error("output enabled outside frame");
    a_cmd_pulse: assert property (@(posedge clock) disable iff (!dev_rst_n)
        cmd_valid |=> !cmd_valid)
        else $error("command pulse too long");
    c_word: cover property (@(posedge clock) disable iff (!dev_rst_n) cmd_valid);
    c_read: cover property (@(posedge clock) disable iff (!dev_rst_n) cmd_valid && !cmd_word.wnr);
    c_two_words: cover property (@(posedge clock) disable iff (!dev_rst_n)
        cmd_valid ##[1:1000] cmd_valid);
endmodule
`default_nettype wire

//--- shared/spi_por_pkg.sv
// Package: constants and carriers for the serial slave port and power-on reset timer
package spi_por_pkg;
    localparam int WORD_BITS = 16;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] LAST_BIT = 4'hF;
    localparam int WNR_BIT = 15;
    localparam int ADDR_MSB = 14;
    localparam int ADDR_LSB = 8;
    localparam int ADDR_W = 7;
    localparam int DATA_MSB = 7;
    localparam int DATA_W = 8;
    localparam int CLK_MHZ = 100;
    localparam int POR_DELAY_MS = 130;
    localparam int POR_CYCLES = POR_DELAY_MS * 1000 * CLK_MHZ;
    localparam int POR_CNT_W = 24;

    typedef struct packed {
        logic wnr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } cmd_word_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [WORD_BITS-1:0] data;
    } rd_resp_t;

    typedef enum logic [1:0] {POR_HOLD, POR_COUNT, POR_RUN} por_state_t;
endpackage

//--- core/por_timer.sv
// Power-on reset release timer on the system clock
`timescale 1ns/10ps
`default_nettype none
module por_timer
    import spi_por_pkg::*;
#(
    parameter int unsigned RELEASE_CYCLES = POR_CYCLES
) (
    input wire logic clock,            // System clock, 100 MHz
    input wire logic supply_ok,        // Supply above threshold, asynchronous
    output logic sys_rst_n             // Released reset, active low
);
    logic ok_meta_ff;
    logic ok_sync_ff;
    logic [POR_CNT_W-1:0] cnt_ff;
    por_state_t state_ff;

    // Loss of supply resets at once, without waiting for a clock
    always_ff @(posedge clock or negedge supply_ok) begin
        if (!supply_ok) begin
            ok_meta_ff <= 1'b0;
            ok_sync_ff <= 1'b0;
        end else begin
            ok_meta_ff <= 1'b1;
            ok_sync_ff <= ok_meta_ff;
        end
    end

    always_ff @(posedge clock or negedge supply_ok) begin
        if (!supply_ok) begin
            state_ff <= POR_HOLD;
            cnt_ff <= '0;
        end else begin
            case (state_ff)
                POR_HOLD: begin
                    if (ok_sync_ff) begin
                        state_ff <= POR_COUNT;
                    end
                end
                POR_COUNT: begin
                    if (cnt_ff == POR_CNT_W'(RELEASE_CYCLES - 1)) begin
                        state_ff <= POR_RUN;
                    end else begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
                POR_RUN: state_ff <= POR_RUN;
                default: state_ff <= POR_HOLD;
            endcase
        end
    end

    assign sys_rst_n = (state_ff == POR_RUN);

    a_release_late: assert property (@(posedge clock) disable iff (!supply_ok)
        $rose(sys_rst_n) |-> $past(cnt_ff) == POR_CNT_W'(RELEASE_CYCLES - 1))
        else $error("reset released before timer expired");
    a_hold_low: assert property (@(posedge clock) disable iff (!supply_ok)
        !ok_sync_ff |-> !sys_rst_n)
        else $error("reset released while supply not settled");
    c_release: cover property (@(posedge clock) disable iff (!supply_ok) $rose(sys_rst_n));
endmodule
`default_nettype wire

//--- tb/spi_master_model.sv
// Behavioural serial master for the slave port
`timescale 1ns/10ps
`default_nettype none
module spi_master_model (
    output logic sclk,   // Serial clock, still between words
    output logic cs_n,   // Chip select, active low
    output logic sdi,    // Data to slave
    input wire logic sdo // Data from slave
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    task automatic frame(input logic en);
        #20 cs_n = !en;
        sdi = ~sdi;
        #20;
    endtask
    // Idle after each word so the reply can cross into the link domain
    task automatic shift(input int n, input logic [15:0] tx, output logic [15:0] rx);
        rx = 16'h0000;
        for (int i = 0; i < n; i++) begin
            sdi = tx[15-i];
            #7.5 rx = {rx[14:0], sdo};
            sclk = 1'b1;
            #7.5 sclk = 1'b0;
        end
        sdi = ~sdi;
        #300;
    endtask
endmodule
`default_nettype wire

//--- tb/spi_slave_framing_test.sv
// Self-checking bench for the serial slave port and reset timer
`timescale 1ns/10ps
`default_nettype none
module spi_slave_framing_test;
    import spi_por_pkg::*;
    logic clock, supply_ok, rst_n, sclk, cs_n, sdi, sdo, sdo_oe, cmd_valid, dev_rst_n;
    cmd_word_t cmd_word;
    cmd_word_t last_cmd = 16'h0000;
    logic [WORD_BITS-1:0] rd_data, rx;
    int mismatches = 0;
    int n_compared = 0;
    int n_valid = 0;
    spi_slave_framing #(.RELEASE_CYCLES(20)) DUT (.clock(clock), .supply_ok(supply_ok),
        .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
        .cmd_valid(cmd_valid), .cmd_word(cmd_word), .rd_data(rd_data), .dev_rst_n(dev_rst_n));
    spi_master_model mst (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) if (cmd_valid === 1'b1) begin
        n_valid <= n_valid + 1;
        last_cmd <= cmd_word;
    end
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic t_por();
        int i;
        supply_ok <= 1'b1;
        rst_n <= 1'b1;
        repeat (15) @(negedge clock);
        check("early release", 16'h0000, 16'(dev_rst_n));
        for (i = 0; i < 40 && dev_rst_n !== 1'b1; i++) @(negedge clock);
        check("release", 16'h0001, 16'(dev_rst_n));
        if (i == 40) conclude();
    endtask
    // Read then write back to back: reply lands in the following word
    task automatic t_exchange();
        int base;
        base = n_valid;
        @(posedge clock) rd_data <= 16'hB71E;
        mst.frame(1'b1);
        check("oe", 16'h0001, 16'(sdo_oe));
        mst.shift(16, 16'h2A00, rx);
        check("first reply", 16'h0000, rx);
        check("read cmd", 16'h2A00, last_cmd);
        mst.shift(16, 16'h95C3, rx);
        check("read reply", 16'hB71E, rx);
        check("write addr", 16'h0015, 16'(last_cmd.addr));
        mst.shift(16, 16'h0000, rx);
        check("write reply", 16'h0000, rx);
        mst.frame(1'b0);
        check("words", 16'(base + 3), 16'(n_valid));
    endtask
    // Partial word and stray clocks outside a frame must be dropped
    task automatic t_partial();
        int base;
        base = n_valid;
        mst.frame(1'b1);
        mst.shift(5, 16'hFFFF, rx);
        mst.frame(1'b0);
        check("oe idle", 16'h0000, 16'(sdo_oe));
        mst.shift(3, 16'hFFFF, rx);
        mst.frame(1'b1);
        mst.shift(16, 16'h4A5C, rx);
        mst.frame(1'b0);
        check("aligned", 16'h4A5C, last_cmd);
        check("count", 16'(base + 1), 16'(n_valid));
    endtask
    task automatic t_powerdown();
        @(posedge clock) rst_n <= 1'b0;
        @(negedge clock);
        check("ext reset", 16'h0000, 16'(dev_rst_n));
        rst_n <= 1'b1;
        @(posedge clock) supply_ok <= 1'b0;
        @(negedge clock);
        check("power down", 16'h0000, 16'(dev_rst_n));
        check("cleared", 16'h0000, cmd_word);
    endtask
    initial begin
        supply_ok = 1'b0;
        rst_n = 1'b0;
        rd_data = 16'h0000;
        repeat (12) @(posedge clock);
        check("held", 16'h0000, 16'(dev_rst_n));
        t_por();
        t_exchange();
        t_partial();
        t_powerdown();
        conclude();
    end
    initial begin
        #200000;
        mismatches++;
        conclude();
    end
endmodule
`default_nettype wire
